/* File: rtl/sweep_pkg.sv */
// Shared constants and types for the sweep and burst mode controller
package sweep_pkg;
   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned CTRL_W  = 10;
   localparam int unsigned TIME_W  = 16;
   localparam int unsigned INDEX_W = 12;

   localparam logic [ADDR_W-1:0] CONTROL_OFFSET   = 8'h00;
   localparam logic [ADDR_W-1:0] BURST_OFFSET     = 8'h04;
   localparam logic [ADDR_W-1:0] INCREMENT_OFFSET = 8'h08;
   localparam logic [ADDR_W-1:0] STEPS_OFFSET     = 8'h0c;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET    = 8'h10;

   // ----------------------------------------------------------------
   // Control word, bit 9 downward
   // ----------------------------------------------------------------
   typedef struct packed {
      logic count_waveform_cycles;       // D9
      logic top_bit_output_enable;       // D8
      logic continuous_or_burst_select;  // D7
      logic burst_source_select;         // D6
      logic increment_source_select;     // D5
      logic sweep_profile;               // D4, 1 = saw
      logic sync_pulse_select;           // D3
      logic sync_output_enable;          // D2
      logic unused_bit;                  // D1
      logic run;                         // D0
   } ctrl_t;

   typedef struct packed {
      logic                 sync_level;
      logic                 output_on;
      logic                 sweep_down;
      logic                 sweep_active;
      logic [INDEX_W-1:0]   step_index;
   } status_t;

   localparam int unsigned STATUS_W = INDEX_W + 4;

   localparam logic [CTRL_W-1:0]  CONTROL_RESET   = 10'h080;
   localparam logic [TIME_W-1:0]  BURST_RESET     = 16'h0010;
   localparam logic [TIME_W-1:0]  INCREMENT_RESET = 16'h0020;
   localparam logic [INDEX_W-1:0] STEPS_RESET     = 12'h004;

   localparam logic [INDEX_W-1:0] INDEX_ZERO = 12'h000;
   localparam logic [INDEX_W-1:0] INDEX_ONE  = 12'h001;
   localparam logic [TIME_W-1:0]  TIME_ZERO  = 16'h0000;
   localparam logic [TIME_W-1:0]  TIME_ONE   = 16'h0001;

   // ----------------------------------------------------------------
   // Sweep sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_UP    = 2'b01,
      ST_DOWN  = 2'b10
   } sweep_state_t;
endpackage : sweep_pkg

/* File: rtl/step_pin_sync.sv */
// Two-stage synchroniser with edge detection for the step control pin
`timescale 1ns/10ps
module step_pin_sync
(
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // First stage is read only by the second
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign o_level = sync_reg;
   assign o_rise  = sync_reg & ~last_reg;
endmodule : step_pin_sync

/* File: rtl/interval_timer.sv */
// Tick counter that reports when a programmed interval has elapsed
`timescale 1ns/10ps
module interval_timer
(
   input  wire logic                       i_clk,
   input  wire logic                       i_reset,
   input  wire logic                       i_restart,
   input  wire logic                       i_tick,
   input  wire logic [sweep_pkg::TIME_W-1:0] i_limit,
   output logic                            o_elapsed
);
   logic [sweep_pkg::TIME_W-1:0] count_reg;
   logic [sweep_pkg::TIME_W-1:0] count_next;
   logic                         at_limit;

   assign at_limit   = (count_reg >= i_limit);
   // Saturates at the limit so a stalled window never wraps
   // The restart cycle is already the first unit of the new window
   assign count_next = i_restart ? (i_tick ? sweep_pkg::TIME_ONE : sweep_pkg::TIME_ZERO) :
                       (i_tick && !at_limit) ? count_reg + sweep_pkg::TIME_ONE :
                       count_reg;

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         count_reg <= sweep_pkg::TIME_ZERO;
      else
         count_reg <= count_next;
   end

   // Not gated by restart: the step logic feeds elapsed back into restart
   assign o_elapsed = at_limit;
endmodule : interval_timer

/* File: rtl/sweep_burst_mode_control.sv */
// Mode control of a frequency sweep generator with a Wishbone register port
//
// Summary of operation
// - Continuous mode: each frequency runs whole interval
// - Burst mode: burst, then midscale till window ends
// - External burst window length follows pin pulses
// - Burst source matters only in burst, external stepping
// - Burst source set: pin gates the burst
// - Burst source clear: burst register times burst
// - Internal stepping ignores the burst source bit
// - External stepping advances only on pin trigger
// - Internal stepping advances at each interval end
// - Saw profile: up to end, restart at start
// - Triangle profile: up to end, then back down
// - Sync select matters only with sync enabled
// - End-of-sweep sync high until first step of next sweep
// - Top bit pin driven only when enabled
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module sweep_burst_mode_control
(
   input  wire logic                          i_clk,
   input  wire logic                          i_reset,
   input  wire logic                          i_wb_cyc,
   input  wire logic                          i_wb_stb,
   input  wire logic                          i_wb_we,
   input  wire logic [sweep_pkg::ADDR_W-1:0]  i_wb_adr,
   input  wire logic [3:0]                    i_wb_sel,
   input  wire logic [sweep_pkg::DATA_W-1:0]  i_wb_dat,
   output logic      [sweep_pkg::DATA_W-1:0]  o_wb_dat,
   output logic                               o_wb_ack,
   input  wire logic                          i_step_ctrl_pin,
   input  wire logic                          i_wave_cycle,
   input  wire logic                          i_wave_msb,
   output logic      [sweep_pkg::INDEX_W-1:0] o_step_index,
   output logic                               o_step_pulse,
   output logic                               o_output_on,
   output logic                               o_sync_output_pin,
   output logic                               o_top_bit_output_pin,
   output logic                               o_top_bit_output_oe
);
   // ----------------------------------------------------------------
   // Registers and wires
   // ----------------------------------------------------------------
   sweep_pkg::ctrl_t                 ctrl_reg;
   logic [sweep_pkg::TIME_W-1:0]     burst_interval_register;
   logic [sweep_pkg::TIME_W-1:0]     increment_interval;
   logic [sweep_pkg::INDEX_W-1:0]    steps_reg;
   logic [sweep_pkg::DATA_W-1:0]     rdata_reg;
   logic                             ack_reg;
   sweep_pkg::sweep_state_t          state_reg;
   sweep_pkg::sweep_state_t          state_next;
   logic [sweep_pkg::INDEX_W-1:0]    index_reg;
   logic [sweep_pkg::INDEX_W-1:0]    index_next;
   logic                             eos_reg;
   logic                             eos_next;
   logic                             step_pulse_reg;
   logic                             output_on_reg;
   logic                             sync_reg;
   logic                             top_bit_reg;
   logic                             run_prev_reg;

   logic                             pin_level;
   logic                             pin_rise;
   logic                             unit_tick;
   logic                             window_elapsed;
   logic                             burst_elapsed;
   logic                             step_now;
   logic                             window_restart;
   logic                             sweep_end;
   logic                             start_now;
   logic                             external_step;
   logic                             external_burst;
   logic                             burst_on;
   logic                             output_on_next;
   logic                             sync_next;
   logic                             bus_req;
   logic                             bus_write;
   sweep_pkg::status_t               status;
   logic [sweep_pkg::DATA_W-1:0]     read_mux;
   logic [sweep_pkg::DATA_W-1:0]     write_merge;

   // ----------------------------------------------------------------
   // Byte-lane merge used by every writable register
   // ----------------------------------------------------------------
   function automatic logic [sweep_pkg::DATA_W-1:0] lane_merge
   (
      input logic [sweep_pkg::DATA_W-1:0] old_value,
      input logic [sweep_pkg::DATA_W-1:0] new_value,
      input logic [3:0]                   sel
   );
      logic [sweep_pkg::DATA_W-1:0] result;
      result = old_value;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
            result[b*8 +: 8] = new_value[b*8 +: 8];
      end
      return result;
   endfunction : lane_merge

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   assign bus_req   = i_wb_cyc & i_wb_stb & ~ack_reg;
   assign bus_write = bus_req & i_wb_we;

   assign status.sync_level   = sync_reg;
   assign status.output_on    = output_on_reg;
   assign status.sweep_down   = (state_reg == sweep_pkg::ST_DOWN);
   assign status.sweep_active = (state_reg != sweep_pkg::ST_IDLE);
   assign status.step_index   = index_reg;

   // Unmapped offsets read zero and ignore writes, but still ack
   assign read_mux =
      (i_wb_adr == sweep_pkg::CONTROL_OFFSET)   ?
         {{(sweep_pkg::DATA_W-sweep_pkg::CTRL_W){1'b0}}, ctrl_reg} :
      (i_wb_adr == sweep_pkg::BURST_OFFSET)     ?
         {{(sweep_pkg::DATA_W-sweep_pkg::TIME_W){1'b0}}, burst_interval_register} :
      (i_wb_adr == sweep_pkg::INCREMENT_OFFSET) ?
         {{(sweep_pkg::DATA_W-sweep_pkg::TIME_W){1'b0}}, increment_interval} :
      (i_wb_adr == sweep_pkg::STEPS_OFFSET)     ?
         {{(sweep_pkg::DATA_W-sweep_pkg::INDEX_W){1'b0}}, steps_reg} :
      (i_wb_adr == sweep_pkg::STATUS_OFFSET)    ?
         {{(sweep_pkg::DATA_W-sweep_pkg::STATUS_W){1'b0}}, status} :
      {sweep_pkg::DATA_W{1'b0}};
   assign write_merge = lane_merge(read_mux, i_wb_dat, i_wb_sel);

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ack_reg   <= 1'b0;
         rdata_reg <= {sweep_pkg::DATA_W{1'b0}};
      end
      else
      begin
         ack_reg   <= bus_req;
         rdata_reg <= bus_req ? read_mux : rdata_reg;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ctrl_reg                <= sweep_pkg::ctrl_t'(sweep_pkg::CONTROL_RESET);
         burst_interval_register <= sweep_pkg::BURST_RESET;
         increment_interval      <= sweep_pkg::INCREMENT_RESET;
         steps_reg               <= sweep_pkg::STEPS_RESET;
      end
      else if (bus_write)
      begin
         case (i_wb_adr)
            sweep_pkg::CONTROL_OFFSET:
               ctrl_reg <= sweep_pkg::ctrl_t'(write_merge[sweep_pkg::CTRL_W-1:0]);
            sweep_pkg::BURST_OFFSET:
               burst_interval_register <= write_merge[sweep_pkg::TIME_W-1:0];
            sweep_pkg::INCREMENT_OFFSET:
               increment_interval <= write_merge[sweep_pkg::TIME_W-1:0];
            sweep_pkg::STEPS_OFFSET:
               steps_reg <= write_merge[sweep_pkg::INDEX_W-1:0];
            default:
               steps_reg <= steps_reg;
         endcase
      end
   end

   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdata_reg;

   // ----------------------------------------------------------------
   // Step pin and interval timers
   // ----------------------------------------------------------------
   step_pin_sync u_pin_sync
   (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_pin   (i_step_ctrl_pin),
      .o_level (pin_level),
      .o_rise  (pin_rise)
   );

   // Intervals count either master clocks or output waveform cycles
   assign unit_tick = ctrl_reg.count_waveform_cycles ? i_wave_cycle : 1'b1;

   assign external_step  = ctrl_reg.increment_source_select;
   // Burst source bit is qualified by burst output and external stepping
   assign external_burst = ~ctrl_reg.continuous_or_burst_select
                         & external_step
                         & ctrl_reg.burst_source_select;

   assign start_now = ctrl_reg.run & ~run_prev_reg;
   assign step_now  = (state_reg != sweep_pkg::ST_IDLE) &
                      (external_step ? pin_rise
                                     : window_elapsed);
   assign window_restart = start_now | step_now;

   interval_timer u_window_timer
   (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_restart (window_restart),
      .i_tick    (unit_tick),
      .i_limit   (increment_interval),
      .o_elapsed (window_elapsed)
   );

   // Restarted at each window start, so an external window resets it too
   interval_timer u_burst_timer
   (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_restart (window_restart),
      .i_tick    (unit_tick),
      .i_limit   (burst_interval_register),
      .o_elapsed (burst_elapsed)
   );

   // ----------------------------------------------------------------
   // Output gating
   // ----------------------------------------------------------------
   assign burst_on = ctrl_reg.continuous_or_burst_select ? 1'b1 :
                     external_burst ? pin_level :
                     window_restart | ~burst_elapsed;
   assign output_on_next = (state_reg != sweep_pkg::ST_IDLE) & burst_on;

   // ----------------------------------------------------------------
   // Sweep sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      index_next = index_reg;
      sweep_end  = 1'b0;
      if (!ctrl_reg.run)
      begin
         state_next = sweep_pkg::ST_IDLE;
         index_next = sweep_pkg::INDEX_ZERO;
      end
      else if (start_now)
      begin
         state_next = sweep_pkg::ST_UP;
         index_next = sweep_pkg::INDEX_ZERO;
      end
      else if (step_now)
      begin
         case (state_reg)
            sweep_pkg::ST_UP:
            begin
               if (index_reg < steps_reg)
                  index_next = index_reg + sweep_pkg::INDEX_ONE;
               else if (ctrl_reg.sweep_profile)
               begin
                  index_next = sweep_pkg::INDEX_ZERO;
                  sweep_end  = 1'b1;
               end
               else if (steps_reg != sweep_pkg::INDEX_ZERO)
               begin
                  state_next = sweep_pkg::ST_DOWN;
                  index_next = index_reg - sweep_pkg::INDEX_ONE;
               end
               else
                  sweep_end = 1'b1;
            end
            sweep_pkg::ST_DOWN:
            begin
               index_next = index_reg - sweep_pkg::INDEX_ONE;
               if (index_reg == sweep_pkg::INDEX_ONE)
               begin
                  state_next = sweep_pkg::ST_UP;
                  sweep_end  = 1'b1;
               end
            end
            default:
            begin
               state_next = sweep_pkg::ST_IDLE;
               index_next = sweep_pkg::INDEX_ZERO;
            end
         endcase
      end
   end

   // Sweep end raises the flag; the first step of the next sweep drops it
   assign eos_next = start_now ? 1'b0 :
                     sweep_end ? 1'b1 :
                     step_now  ? 1'b0 :
                     eos_reg;

   // ----------------------------------------------------------------
   // Sync pin
   // ----------------------------------------------------------------
   assign sync_next = ctrl_reg.sync_output_enable &
                      (ctrl_reg.sync_pulse_select ? eos_next
                                                  : step_now);

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state_reg      <= sweep_pkg::ST_IDLE;
         index_reg      <= sweep_pkg::INDEX_ZERO;
         eos_reg        <= 1'b0;
         step_pulse_reg <= 1'b0;
         output_on_reg  <= 1'b0;
         sync_reg       <= 1'b0;
         run_prev_reg   <= 1'b0;
      end
      else
      begin
         state_reg      <= state_next;
         index_reg      <= index_next;
         eos_reg        <= eos_next;
         step_pulse_reg <= step_now;
         output_on_reg  <= output_on_next;
         sync_reg       <= sync_next;
         run_prev_reg   <= ctrl_reg.run;
      end
   end

   // ----------------------------------------------------------------
   // Top bit pin
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         top_bit_reg <= 1'b0;
      else
         top_bit_reg <= i_wave_msb & ctrl_reg.top_bit_output_enable;
   end

   assign o_top_bit_output_pin = top_bit_reg;
   assign o_top_bit_output_oe  = ctrl_reg.top_bit_output_enable;

   assign o_step_index      = index_reg;
   assign o_step_pulse      = step_pulse_reg;
   assign o_output_on       = output_on_reg;
   assign o_sync_output_pin = sync_reg;
endmodule : sweep_burst_mode_control

/* File: verif/step_pin_model.sv */
// Behavioural outside controller that drives the step control pin
`timescale 1ns/10ps
module step_pin_model
(
   input  wire logic i_clk,
   output logic      o_pin
);
   initial o_pin = 1'b0;

   // Each level held two clocks at least, else the synchroniser may miss it
   task automatic pulse(input int hi, input int lo);
      @(posedge i_clk);
      o_pin <= 1'b1;
      repeat ((hi < 2) ? 2 : hi) @(posedge i_clk);
      o_pin <= 1'b0;
      repeat ((lo < 2) ? 2 : lo) @(posedge i_clk);
   endtask : pulse
endmodule : step_pin_model

/* File: verif/sweep_burst_mode_control_assertions.sv */
// Port-level checks for the sweep and burst mode controller
`timescale 1ns/10ps
module sweep_burst_mode_control_assertions
(
   input wire logic                          i_clk,
   input wire logic                          i_reset,
   input wire logic                          i_wb_cyc,
   input wire logic                          i_wb_stb,
   input wire logic [sweep_pkg::DATA_W-1:0]  o_wb_dat,
   input wire logic                          o_wb_ack,
   input wire logic                          i_wave_msb,
   input wire logic [sweep_pkg::INDEX_W-1:0] o_step_index,
   input wire logic                          o_step_pulse,
   input wire logic                          o_top_bit_output_pin,
   input wire logic                          o_top_bit_output_oe
);
   wire logic req;
   wire logic moved;
   assign req = i_wb_cyc && i_wb_stb;
   assign moved = (o_step_index != 12'h000);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   // ------------
   // Checks
   // ------------
   a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (req && !o_wb_ack |=> o_wb_ack)
      else $error("request not answered next cycle");
   a_read_hold: assert property (!req && !o_wb_ack |=> $stable(o_wb_dat))
      else $error("read data moved without request");
   a_msb_off: assert property (!o_top_bit_output_oe |-> !o_top_bit_output_pin)
      else $error("top bit driven while disabled");
   a_msb_follow: assert property (o_top_bit_output_oe && $past(o_top_bit_output_oe)
      |-> o_top_bit_output_pin == $past(i_wave_msb))
      else $error("top bit does not follow phase");
   a_index_step: assert property ($changed(o_step_index) && moved
      |-> o_step_index == $past(o_step_index) + 12'h001
       || o_step_index == $past(o_step_index) - 12'h001)
      else $error("index jumped by more than one");
   a_index_pulse: assert property ($changed(o_step_index) && moved
      |-> ##[0:1] o_step_pulse)
      else $error("step without step pulse");
   a_pulse_cause: assert property (o_step_pulse
      |-> $past(o_step_index) != o_step_index
       || $past(o_step_index, 2) != $past(o_step_index))
      else $error("step pulse without index change");
   c_wrap: cover property (o_step_pulse && !moved);
   c_msb: cover property (o_top_bit_output_oe && o_top_bit_output_pin);
   c_read: cover property (o_wb_ack && o_wb_dat != 32'h0);
endmodule : sweep_burst_mode_control_assertions

bind sweep_burst_mode_control sweep_burst_mode_control_assertions i_chk
(
   .i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_wave_msb(i_wave_msb),
   .o_step_index(o_step_index), .o_step_pulse(o_step_pulse),
   .o_top_bit_output_pin(o_top_bit_output_pin), .o_top_bit_output_oe(o_top_bit_output_oe)
);

/* File: verif/sweep_burst_mode_control_test.sv */
// Self-checking bench for the sweep and burst mode controller
`timescale 1ns/10ps
module sweep_burst_mode_control_test;
   logic             i_clk, i_reset, cyc, stb, we, ack, pin, msb, step, on, sync, top, oe, wcyc;
   logic [7:0]       adr;
   logic [31:0]      wdat, o_dat, rd;
   logic [11:0]      idx;
   logic [5:0][7:0]  ra = {8'h14, 8'h10, 8'h0c, 8'h08, 8'h04, 8'h00};
   logic [5:0][31:0] rv = {32'h0, 32'h0, 32'h4, 32'h20, 32'h10, 32'h80};
   int               errors, cmp_count, k, o, n;

   sweep_burst_mode_control i_dut
   (
      .i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(o_dat), .o_wb_ack(ack),
      .i_step_ctrl_pin(pin), .i_wave_cycle(wcyc), .i_wave_msb(msb), .o_step_index(idx),
      .o_step_pulse(step), .o_output_on(on), .o_sync_output_pin(sync),
      .o_top_bit_output_pin(top), .o_top_bit_output_oe(oe)
   );
   step_pin_model i_drv (.i_clk(i_clk), .o_pin(pin));

   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic summarize();
      $display("errors %0d, comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   // Request held until ack is seen at a rising edge, then dropped
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      while (ack !== 1'b1) @(posedge i_clk);
      rd = o_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic mode(input logic [31:0] v);
      wb(1'b1, sweep_pkg::CONTROL_OFFSET, 32'h0);
      wb(1'b1, sweep_pkg::CONTROL_OFFSET, v);
   endtask : mode

   // Cycles up to the next step pulse, and how many of them had output on
   task automatic wait_step(output int c, output int h);
      c = 0;
      h = 0;
      do
      begin
         @(posedge i_clk);
         c++;
         h += int'(on);
      end
      while (step !== 1'b1 && c < 400);
      if (step !== 1'b1)
         errors++;
   endtask : wait_step

   // Index list packed four bits per step, first step in the low nibble
   task automatic sweep(input logic [31:0] v, input logic [23:0] e, input logic [5:0] s);
      mode(v);
      for (int j = 0; j < 6; j++)
      begin
         wait_step(k, o);
         @(posedge i_clk);
         check({20'h0, idx}, {28'h0, e[j*4 +: 4]});
         check({31'h0, sync}, {31'h0, s[j]});
      end
   endtask : sweep

   task automatic pin_on(input int hi, input int lo, input int exp);
      repeat (10) @(posedge i_clk);
      fork
         i_drv.pulse(hi, lo);
         begin
            n = 0;
            repeat (hi + lo + 4) @(posedge i_clk) n += int'(on);
         end
      join
      check(32'(n), 32'(exp));
   endtask : pin_on

   initial
   begin
      repeat (20000) @(posedge i_clk);
      errors++;
      summarize();
   end

   initial
   begin
      {i_reset, cyc, stb, we, msb, wcyc, adr, wdat, errors, cmp_count} = '0;
      i_reset = 1'b1;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      wb(1'b1, sweep_pkg::STATUS_OFFSET, 32'hffffffff);
      wb(1'b1, 8'h14, 32'hffffffff);
      for (int j = 0; j < 6; j++)
      begin
         wb(1'b0, ra[j], 32'h0);
         check(rd, rv[j]);
      end
      check({31'h0, oe}, 32'h0);
      wb(1'b1, sweep_pkg::BURST_OFFSET, 32'h3);
      wb(1'b1, sweep_pkg::INCREMENT_OFFSET, 32'h8);
      wb(1'b1, sweep_pkg::STEPS_OFFSET, 32'h3);
      sweep(32'h089, 24'h012321, 6'b000000);
      wait_step(k, o);
      wait_step(k, o);
      check(32'(k), 32'h8);
      check(32'(o), 32'h8);
      sweep(32'h09d, 24'h210321, 6'b001000);
      mode(32'h051);
      wait_step(k, o);
      wait_step(k, o);
      check(32'(k), 32'h8);
      check(32'(o), 32'h3);
      mode(32'h0b1);
      repeat (40) @(posedge i_clk);
      check({20'h0, idx}, 32'h0);
      i_drv.pulse(3, 3);
      wb(1'b0, sweep_pkg::STATUS_OFFSET, 32'h0);
      check(rd, 32'h5001);
      mode(32'h071);
      pin_on(6, 6, 6);
      mode(32'h031);
      pin_on(6, 10, 3);
      // Intervals in waveform cycles: no cycles, no step, burst never ends
      mode(32'h211);
      repeat (40) @(posedge i_clk);
      check({19'h0, on, idx}, 32'h1000);
      wcyc <= 1'b1;
      wait_step(k, o);
      wait_step(k, o);
      check(32'(k), 32'h8);
      check(32'(o), 32'h3);
      mode(32'h100);
      msb <= 1'b1;
      repeat (3) @(posedge i_clk);
      check({30'h0, oe, top}, 32'h3);
      msb <= 1'b0;
      repeat (3) @(posedge i_clk);
      check({30'h0, oe, top}, 32'h2);
      wb(1'b1, sweep_pkg::CONTROL_OFFSET, 32'h0);
      repeat (2) @(posedge i_clk);
      check({31'h0, oe}, 32'h0);
      summarize();
   end
endmodule : sweep_burst_mode_control_test
